// ### include/pstat_pkg.sv
// Package with the statistics bank map, frame limits and counter indices
package pstat_pkg;

   // ------------------------------------------------------------------
   // Register offsets (byte addresses)
   // ------------------------------------------------------------------
   localparam logic [15:0] OFS_BASE                 = 16'hed00;
   localparam logic [15:0] OFS_RX_OCTET_TOTAL       = 16'hed00;
   localparam logic [15:0] OFS_RX_SHORT_GOOD_FCS    = 16'hed04;
   localparam logic [15:0] OFS_RX_SHORT_ERRORED     = 16'hed08;
   localparam logic [15:0] OFS_RX_LONG_GOOD_FCS     = 16'hed0c;
   localparam logic [15:0] OFS_RX_LONG_ERRORED      = 16'hed10;
   localparam logic [15:0] OFS_RX_BAD_SYMBOL        = 16'hed14;
   localparam logic [15:0] OFS_RX_FCS_FAIL          = 16'hed18;
   localparam logic [15:0] OFS_RX_PARTIAL_BYTE_FAIL = 16'hed1c;
   localparam logic [15:0] OFS_RX_MAC_CTRL_FRAMES   = 16'hed20;
   localparam logic [15:0] OFS_RX_FLOW_PAUSE_FRAMES = 16'hed24;
   localparam logic [15:0] OFS_RX_GOOD_BCAST        = 16'hed28;
   localparam logic [15:0] OFS_RX_GOOD_MCAST        = 16'hed2c;
   localparam logic [15:0] OFS_RX_GOOD_UCAST        = 16'hed30;
   localparam logic [15:0] OFS_RX_LEN_MIN_BUCKET    = 16'hed34;
   localparam logic [15:0] OFS_RX_LEN_BUCKET_TWO    = 16'hed38;
   localparam logic [15:0] OFS_RX_LEN_BUCKET_THREE  = 16'hed3c;
   localparam logic [15:0] OFS_RX_LEN_BUCKET_FOUR   = 16'hed40;
   localparam logic [15:0] OFS_RX_LEN_BUCKET_FIVE   = 16'hed44;
   localparam logic [15:0] OFS_RX_LEN_BUCKET_SIX    = 16'hed48;
   localparam logic [15:0] OFS_RX_LEN_BUCKET_SEVEN  = 16'hed4c;
   localparam logic [15:0] OFS_RX_LEN_BUCKET_TOP    = 16'hed50;
   localparam logic [15:0] OFS_TX_OCTET_TOTAL       = 16'hed54;
   localparam logic [15:0] OFS_TX_LATE_COLLIDE      = 16'hed58;
   localparam logic [15:0] OFS_TX_FLOW_PAUSE_FRAMES = 16'hed5c;
   localparam logic [15:0] OFS_TX_GOOD_BCAST        = 16'hed60;
   localparam logic [15:0] OFS_TX_GOOD_MCAST        = 16'hed64;
   localparam logic [15:0] OFS_TX_GOOD_UCAST        = 16'hed68;
   localparam logic [15:0] OFS_TX_WAITED_MEDIUM     = 16'hed6c;
   localparam logic [15:0] OFS_TX_ALL_COLLIDE       = 16'hed70;
   localparam logic [15:0] OFS_TX_ABANDONED_COLLIDE = 16'hed74;
   localparam logic [15:0] OFS_TX_ONE_COLLIDE_OK    = 16'hed78;
   localparam logic [15:0] OFS_TX_MULTI_COLLIDE_OK  = 16'hed7c;
   localparam logic [15:0] OFS_PORT_CTRL            = 16'hed80;

   // ------------------------------------------------------------------
   // Layout, reset values and frame limits
   // ------------------------------------------------------------------
   localparam int          NUM_COUNTERS      = 32;
   localparam int          CTRL_HALF_DUPLEX  = 0;
   localparam logic        RST_HALF_DUPLEX   = 1'b0;
   localparam logic [31:0] RST_COUNTER       = 32'h0000_0000;
   localparam logic [15:0] FRAME_MIN_LEN     = 16'h0040;
   localparam logic [15:0] FRAME_MAX_LEN     = 16'h07d0;
   localparam logic [15:0] BUCKET_TWO_HI     = 16'h007f;
   localparam logic [15:0] BUCKET_THREE_HI   = 16'h00ff;
   localparam logic [15:0] BUCKET_FOUR_HI    = 16'h01ff;
   localparam logic [15:0] BUCKET_FIVE_HI    = 16'h03ff;
   localparam logic [15:0] BUCKET_SIX_HI     = 16'h05f1;
   localparam logic [15:0] ETHERTYPE_MAC_CTL = 16'h8808;
   localparam logic [15:0] OPCODE_PAUSE      = 16'h0001;

   // Word index of a counter inside the bank
   function automatic logic [4:0] ofsIdx(input logic [15:0] ofs);
      logic [15:0] diff;
      diff = ofs - OFS_BASE;
      return diff[6:2];
   endfunction : ofsIdx

endpackage : pstat_pkg

// ### design/pstat_counter.sv
// One clear-on-read statistics counter
`timescale 1ns/100ps
module pstat_counter
   import pstat_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        clear,
   input  wire logic [31:0] incr,
   output logic      [31:0] value
);

   logic [31:0] next_value;

   // ------------------------------------------------------------------
   // Count
   // ------------------------------------------------------------------
   // Clear first, then add, so an event in the read cycle survives
   assign next_value = (clear ? RST_COUNTER : value) + incr;

   always_ff @(posedge clk) begin
      if (rst) begin
         value <= RST_COUNTER;
      end else begin
         value <= next_value;
      end
   end

endmodule : pstat_counter

// ### design/pstat_counters.sv
// Port statistics counter bank with a classic Wishbone slave
// Behaviour
// - Receive octets summed over all frames
// - Short frames with good checksum counted
// - Short frames with any error counted
// - Long frames with good checksum counted
// - Long frames with any error counted
// - Legal-length frames with symbol errors counted
// - Legal whole-byte frames with bad checksum
// - Legal partial-byte frames with bad checksum
// - Every received MAC control frame counted
// - Pause frames need full qualification
// - Good broadcast, multicast, unicast counted apart
// - Received frames of 64 octets or more sorted by length
// - Transmit octets of good frames summed
// - Late collisions counted per event
// - Sent pause frames counted
// - Good transmitted frames split by address
// - Frames whose first attempt deferred
// - All collisions counted, half duplex only
// - Frames abandoned on excessive collisions
// - Single and multiple collision successes
// - Reading a counter with any byte lane selected clears it
// - Read-only 32-bit counters, zero after reset
//
// Chosen here: register access over Wishbone.
`timescale 1ns/100ps
module pstat_counters
   import pstat_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        wbCyc,
   input  wire logic        wbStb,
   input  wire logic        wbWe,
   input  wire logic [15:0] wbAdr,
   input  wire logic [3:0]  wbSel,
   input  wire logic [31:0] wbDatIn,
   output logic      [31:0] wbDatOut,
   output logic             wbAck,
   input  wire logic        rxFrameDone,
   input  wire logic [15:0] rxFrameLen,
   input  wire logic        rxFcsBad,
   input  wire logic        rxSymbolErr,
   input  wire logic        rxPartialByte,
   input  wire logic [15:0] rxTypeLen,
   input  wire logic [15:0] rxOpcode,
   input  wire logic        rxDaPause,
   input  wire logic        rxDaBcast,
   input  wire logic        rxDaMcast,
   input  wire logic        txFrameDone,
   input  wire logic        txFrameErr,
   input  wire logic [15:0] txFrameLen,
   input  wire logic        txIsPause,
   input  wire logic        txDaBcast,
   input  wire logic        txDaMcast,
   input  wire logic        tx_waited_medium,
   input  wire logic [4:0]  txCollCount,
   input  wire logic        txCollisionEvt,
   input  wire logic        txLateCollEvt,
   input  wire logic        txAbandoned
);

   // ------------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------------
   function automatic logic [31:0] bump(input logic c);
      return c ? 32'h0000_0001 : 32'h0000_0000;
   endfunction : bump

   function automatic logic inRange(input logic [15:0] len,
                                    input logic [15:0] lo,
                                    input logic [15:0] hi);
      return (len >= lo) && (len <= hi);
   endfunction : inRange

   // ------------------------------------------------------------------
   // Declarations
   // ------------------------------------------------------------------
   logic [31:0] cnt      [NUM_COUNTERS];
   logic [31:0] incr     [NUM_COUNTERS];
   logic [NUM_COUNTERS-1:0] clearVec;
   logic        halfDuplex;
   logic [31:0] next_wbDatOut;
   logic        reqNew;
   logic        hitBank;
   logic        hitCtrl;
   logic        rdBank;
   logic        wrCtrl;
   logic [4:0]  rdIdx;
   logic [31:0] bankData;
   logic [31:0] ctrlData;
   logic        rxErr;
   logic        rxShort;
   logic        rxLong;
   logic        rxLegal;
   logic        rxGood;
   logic        rxCtrl;
   logic        rxPause;
   logic        txGood;

   // ------------------------------------------------------------------
   // Wishbone decode
   // ------------------------------------------------------------------
   // Ack one cycle after the strobe; unmapped words answer zero, never stall
   assign reqNew   = wbCyc & wbStb & ~wbAck;
   assign hitBank  = (wbAdr[15:7] == OFS_BASE[15:7]);
   assign hitCtrl  = (wbAdr[15:2] == OFS_PORT_CTRL[15:2]);
   assign rdIdx    = wbAdr[6:2];
   assign rdBank   = reqNew & ~wbWe & hitBank & (|wbSel);
   assign wrCtrl   = reqNew & wbWe & hitCtrl & wbSel[0];
   assign bankData = cnt[rdIdx];
   assign ctrlData = {31'h0000_0000, halfDuplex};
   assign next_wbDatOut = wbWe    ? 32'h0000_0000 :
                          hitBank ? bankData :
                          hitCtrl ? ctrlData : 32'h0000_0000;

   always_ff @(posedge clk) begin
      if (rst) begin
         wbAck <= 1'b0;
      end else begin
         wbAck <= reqNew;
      end
   end

   // Data captured in the same edge that clears the counter
   always_ff @(posedge clk) begin
      if (rst) begin
         wbDatOut <= RST_COUNTER;
      end else if (reqNew) begin
         wbDatOut <= next_wbDatOut;
      end
   end

   // Counters ignore writes; only the control word is writable
   always_ff @(posedge clk) begin
      if (rst) begin
         halfDuplex <= RST_HALF_DUPLEX;
      end else if (wrCtrl) begin
         halfDuplex <= wbDatIn[CTRL_HALF_DUPLEX];
      end
   end

   // ------------------------------------------------------------------
   // Receive classification
   // ------------------------------------------------------------------
   assign rxErr   = rxFcsBad | rxSymbolErr | rxPartialByte;
   assign rxShort = rxFrameLen < FRAME_MIN_LEN;
   assign rxLong  = rxFrameLen > FRAME_MAX_LEN;
   assign rxLegal = ~rxShort & ~rxLong;
   assign rxGood  = rxFrameDone & rxLegal & ~rxErr;
   assign rxCtrl  = rxTypeLen == ETHERTYPE_MAC_CTL;
   assign rxPause = rxCtrl & rxDaPause & (rxOpcode == OPCODE_PAUSE) & ~rxShort
                    & ~rxFcsBad;

   assign incr[ofsIdx(OFS_RX_OCTET_TOTAL)] =
      rxFrameDone ? {16'h0000, rxFrameLen} : 32'h0000_0000;
   assign incr[ofsIdx(OFS_RX_SHORT_GOOD_FCS)] =
      bump(rxFrameDone & rxShort & ~rxFcsBad);
   assign incr[ofsIdx(OFS_RX_SHORT_ERRORED)] =
      bump(rxFrameDone & rxShort & rxErr);
   assign incr[ofsIdx(OFS_RX_LONG_GOOD_FCS)] =
      bump(rxFrameDone & rxLong & ~rxFcsBad);
   assign incr[ofsIdx(OFS_RX_LONG_ERRORED)] =
      bump(rxFrameDone & rxLong & rxErr);
   assign incr[ofsIdx(OFS_RX_BAD_SYMBOL)] =
      bump(rxFrameDone & rxLegal & rxSymbolErr);
   assign incr[ofsIdx(OFS_RX_FCS_FAIL)] =
      bump(rxFrameDone & rxLegal & ~rxPartialByte & rxFcsBad);
   assign incr[ofsIdx(OFS_RX_PARTIAL_BYTE_FAIL)] =
      bump(rxFrameDone & rxLegal & rxPartialByte & rxFcsBad);
   assign incr[ofsIdx(OFS_RX_MAC_CTRL_FRAMES)] =
      bump(rxFrameDone & rxCtrl);
   assign incr[ofsIdx(OFS_RX_FLOW_PAUSE_FRAMES)] =
      bump(rxFrameDone & rxPause);
   // Broadcast takes priority so one frame never lands in two classes
   assign incr[ofsIdx(OFS_RX_GOOD_BCAST)] =
      bump(rxGood & rxDaBcast);
   assign incr[ofsIdx(OFS_RX_GOOD_MCAST)] =
      bump(rxGood & rxDaMcast & ~rxDaBcast & ~rxCtrl);
   assign incr[ofsIdx(OFS_RX_GOOD_UCAST)] =
      bump(rxGood & ~rxDaMcast & ~rxDaBcast);

   // Buckets see every frame of 64 octets or more, errored or not
   assign incr[ofsIdx(OFS_RX_LEN_MIN_BUCKET)] =
      bump(rxFrameDone & (rxFrameLen == FRAME_MIN_LEN));
   assign incr[ofsIdx(OFS_RX_LEN_BUCKET_TWO)] =
      bump(rxFrameDone & inRange(rxFrameLen, FRAME_MIN_LEN + 16'h0001,
                                 BUCKET_TWO_HI));
   assign incr[ofsIdx(OFS_RX_LEN_BUCKET_THREE)] =
      bump(rxFrameDone & inRange(rxFrameLen, BUCKET_TWO_HI + 16'h0001,
                                 BUCKET_THREE_HI));
   assign incr[ofsIdx(OFS_RX_LEN_BUCKET_FOUR)] =
      bump(rxFrameDone & inRange(rxFrameLen, BUCKET_THREE_HI + 16'h0001,
                                 BUCKET_FOUR_HI));
   assign incr[ofsIdx(OFS_RX_LEN_BUCKET_FIVE)] =
      bump(rxFrameDone & inRange(rxFrameLen, BUCKET_FOUR_HI + 16'h0001,
                                 BUCKET_FIVE_HI));
   assign incr[ofsIdx(OFS_RX_LEN_BUCKET_SIX)] =
      bump(rxFrameDone & inRange(rxFrameLen, BUCKET_FIVE_HI + 16'h0001,
                                 BUCKET_SIX_HI));
   assign incr[ofsIdx(OFS_RX_LEN_BUCKET_SEVEN)] =
      bump(rxFrameDone & inRange(rxFrameLen, BUCKET_SIX_HI + 16'h0001,
                                 FRAME_MAX_LEN));
   assign incr[ofsIdx(OFS_RX_LEN_BUCKET_TOP)] =
      bump(rxFrameDone & rxLong);

   // ------------------------------------------------------------------
   // Transmit classification
   // ------------------------------------------------------------------
   // The MAC flags late collisions itself; the 512 bit-time window is its own
   assign txGood = txFrameDone & ~txFrameErr;

   assign incr[ofsIdx(OFS_TX_OCTET_TOTAL)] =
      txGood ? {16'h0000, txFrameLen} : 32'h0000_0000;
   assign incr[ofsIdx(OFS_TX_LATE_COLLIDE)] =
      bump(txLateCollEvt);
   assign incr[ofsIdx(OFS_TX_FLOW_PAUSE_FRAMES)] =
      bump(txGood & txIsPause);
   assign incr[ofsIdx(OFS_TX_GOOD_BCAST)] =
      bump(txGood & txDaBcast);
   assign incr[ofsIdx(OFS_TX_GOOD_MCAST)] =
      bump(txGood & txDaMcast & ~txDaBcast);
   assign incr[ofsIdx(OFS_TX_GOOD_UCAST)] =
      bump(txGood & ~txDaMcast & ~txDaBcast);
   assign incr[ofsIdx(OFS_TX_WAITED_MEDIUM)] =
      bump(txFrameDone & tx_waited_medium);
   // Full duplex cannot collide; stray events there are dropped
   assign incr[ofsIdx(OFS_TX_ALL_COLLIDE)] =
      bump(txCollisionEvt & halfDuplex);
   assign incr[ofsIdx(OFS_TX_ABANDONED_COLLIDE)] =
      bump(txAbandoned);
   assign incr[ofsIdx(OFS_TX_ONE_COLLIDE_OK)] =
      bump(txGood & (txCollCount == 5'h01));
   assign incr[ofsIdx(OFS_TX_MULTI_COLLIDE_OK)] =
      bump(txGood & (txCollCount > 5'h01));

   // ------------------------------------------------------------------
   // Counter bank
   // ------------------------------------------------------------------
   for (genvar i = 0; i < NUM_COUNTERS; i++) begin : g_cnt
      assign clearVec[i] = rdBank & (rdIdx == 5'(i));
      pstat_counter u_cnt (
         .clk   (clk),
         .rst   (rst),
         .clear (clearVec[i]),
         .incr  (incr[i]),
         .value (cnt[i])
      );
   end

   // ------------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   sequence s_readReq;
      reqNew && !wbWe && hitBank && (|wbSel);
   endsequence

   sequence s_ackedOnce;
      wbAck ##1 !wbAck;
   endsequence

   chk_read_data_clear: assert property (
      (s_readReq and (incr[rdIdx] == 32'h0000_0000)) |=>
         (wbDatOut == $past(bankData)) && (cnt[$past(rdIdx)] == 32'h0000_0000))
      else $error("read did not return and clear the counter");

   chk_ack_single: assert property (
      reqNew |=> s_ackedOnce)
      else $error("ack not a single cycle after request");

   chk_keep_event: assert property (
      (s_readReq and (rdIdx == ofsIdx(OFS_RX_OCTET_TOTAL)) and rxFrameDone) |=>
         cnt[ofsIdx(OFS_RX_OCTET_TOTAL)] == {16'h0000, $past(rxFrameLen)})
      else $error("frame during read was lost");

   chk_rx_octets: assert property (
      (rxFrameDone && !clearVec[ofsIdx(OFS_RX_OCTET_TOTAL)]) |=>
         cnt[ofsIdx(OFS_RX_OCTET_TOTAL)] ==
            $past(cnt[ofsIdx(OFS_RX_OCTET_TOTAL)]) + {16'h0000, $past(rxFrameLen)})
      else $error("receive octet sum wrong");

   chk_short_good: assert property (
      (rxFrameDone && (rxFrameLen < FRAME_MIN_LEN) && !rxFcsBad &&
       !clearVec[ofsIdx(OFS_RX_SHORT_GOOD_FCS)]) |=>
         cnt[ofsIdx(OFS_RX_SHORT_GOOD_FCS)] ==
            $past(cnt[ofsIdx(OFS_RX_SHORT_GOOD_FCS)]) + 32'h0000_0001)
      else $error("short good frame not counted");

   chk_long_errored: assert property (
      (rxFrameDone && (rxFrameLen > FRAME_MAX_LEN) && rxSymbolErr &&
       !clearVec[ofsIdx(OFS_RX_LONG_ERRORED)]) |=>
         cnt[ofsIdx(OFS_RX_LONG_ERRORED)] ==
            $past(cnt[ofsIdx(OFS_RX_LONG_ERRORED)]) + 32'h0000_0001)
      else $error("long errored frame not counted");

   chk_bucket_min: assert property (
      (rxFrameDone && (rxFrameLen == 16'h0041) &&
       !clearVec[ofsIdx(OFS_RX_LEN_MIN_BUCKET)]) |=>
         $stable(cnt[ofsIdx(OFS_RX_LEN_MIN_BUCKET)]))
      else $error("65-octet frame landed in the 64 bucket");

   // Modulo-2^32 sum, so the all-ones step to zero is covered too
   chk_counter_wrap: assert property (
      (txLateCollEvt && !clearVec[ofsIdx(OFS_TX_LATE_COLLIDE)]) |=>
         cnt[ofsIdx(OFS_TX_LATE_COLLIDE)] ==
            $past(cnt[ofsIdx(OFS_TX_LATE_COLLIDE)]) + 32'h0000_0001)
      else $error("late collision count did not step or wrap");

   chk_full_duplex: assert property (
      (!halfDuplex && !clearVec[ofsIdx(OFS_TX_ALL_COLLIDE)]) |=>
         $stable(cnt[ofsIdx(OFS_TX_ALL_COLLIDE)]))
      else $error("collision counted in full duplex");

   chk_single_coll: assert property (
      (txGood && (txCollCount == 5'h01) &&
       !clearVec[ofsIdx(OFS_TX_ONE_COLLIDE_OK)]) |=>
         (cnt[ofsIdx(OFS_TX_ONE_COLLIDE_OK)] ==
            $past(cnt[ofsIdx(OFS_TX_ONE_COLLIDE_OK)]) + 32'h0000_0001) &&
         $stable(cnt[ofsIdx(OFS_TX_MULTI_COLLIDE_OK)]))
      else $error("single collision success miscounted");

   chk_pause_rx: assert property (
      (rxFrameDone && rxFcsBad && !clearVec[ofsIdx(OFS_RX_FLOW_PAUSE_FRAMES)]) |=>
         $stable(cnt[ofsIdx(OFS_RX_FLOW_PAUSE_FRAMES)]))
      else $error("pause frame with bad checksum counted");

   chk_tx_octets: assert property (
      (txGood && !clearVec[ofsIdx(OFS_TX_OCTET_TOTAL)]) |=>
         cnt[ofsIdx(OFS_TX_OCTET_TOTAL)] ==
            $past(cnt[ofsIdx(OFS_TX_OCTET_TOTAL)]) + {16'h0000, $past(txFrameLen)})
      else $error("transmit octet sum wrong");

   chk_mcast_ctrl: assert property (
      (rxFrameDone && rxCtrl && rxDaMcast && !rxDaBcast &&
       !clearVec[ofsIdx(OFS_RX_GOOD_MCAST)]) |=>
         $stable(cnt[ofsIdx(OFS_RX_GOOD_MCAST)]))
      else $error("control frame counted as multicast");

   chk_tx_errored: assert property (
      (txFrameDone && txFrameErr && !clearVec[ofsIdx(OFS_TX_GOOD_UCAST)]) |=>
         $stable(cnt[ofsIdx(OFS_TX_GOOD_UCAST)]))
      else $error("errored frame counted as good unicast");

endmodule : pstat_counters

// ### testbench/pstat_mac_model.sv
// Behavioural MAC datapath handing one-cycle frame events to the counter bank
`timescale 1ns/100ps
module pstat_mac_model (
   input  wire logic        clk,
   output logic             rxEvt = 1'b0,
   output logic      [53:0] rxQual = 54'h0,
   output logic             txEvt = 1'b0,
   output logic      [25:0] txQual = 26'h0,
   output logic      [2:0]  txPulse = 3'h0
);
   // ---------------------------------------------------------------
   // Frame hand-off
   // ---------------------------------------------------------------
   // Qualifiers mean nothing off the strobe, so they churn there rather
   // than hold values that a sloppy bank might still count
   task automatic sendRx(input logic [53:0] q);
      {rxEvt, rxQual} <= {1'b1, q};
      @(posedge clk);
      rxEvt <= 1'b0;
      rxQual <= 54'({$urandom, $urandom});
      @(posedge clk);
   endtask : sendRx

   task automatic sendTx(input logic [25:0] q, input logic [2:0] p);
      {txEvt, txQual, txPulse} <= {1'b1, q, p};
      @(posedge clk);
      {txEvt, txPulse} <= 4'h0;
      txQual <= 26'($urandom);
      @(posedge clk);
   endtask : sendTx
endmodule : pstat_mac_model

// ### testbench/test_pstat_counters.sv
// Self-checking bench for the port statistics counter bank
`timescale 1ns/100ps
module test_pstat_counters;
   import pstat_pkg::*;
   logic        clk = 1'b0, rst = 1'b1, wbCyc = 1'b0, wbStb = 1'b0, wbWe = 1'b0;
   logic [15:0] wbAdr = 16'h0000;
   logic [3:0]  wbSel = 4'h0, selMask = 4'hf;
   logic [31:0] wbDatIn = 32'h0, wbDatOut, want, oldVal;
   logic        wbAck, rxEvt, txEvt, halfDup = 1'b0;
   logic [53:0] rxQual;
   logic [25:0] txQual;
   logic [2:0]  txPulse;
   logic [31:0] expQ[$];
   logic [31:0] expCnt[32] = '{default: 32'h0};
   logic [15:0] lenTab[16] = '{16'h003f, 16'h0040, 16'h0041, 16'h007f, 16'h0080, 16'h00ff,
      16'h0100, 16'h01ff, 16'h0200, 16'h03ff, 16'h0400, 16'h05f1, 16'h05f2, 16'h07d0,
      16'h07d1, 16'h0020};
   logic [15:0] bucketHi[8] = '{FRAME_MIN_LEN, BUCKET_TWO_HI, BUCKET_THREE_HI, BUCKET_FOUR_HI,
      BUCKET_FIVE_HI, BUCKET_SIX_HI, FRAME_MAX_LEN, 16'hffff};
   int          miscompares = 0, checked = 0;

   pstat_counters pstat_counters_inst (
      .clk(clk), .rst(rst), .wbCyc(wbCyc), .wbStb(wbStb), .wbWe(wbWe), .wbAdr(wbAdr),
      .wbSel(wbSel), .wbDatIn(wbDatIn), .wbDatOut(wbDatOut), .wbAck(wbAck),
      .rxFrameDone(rxEvt), .rxFrameLen(rxQual[53:38]), .rxFcsBad(rxQual[37]),
      .rxSymbolErr(rxQual[36]), .rxPartialByte(rxQual[35]), .rxTypeLen(rxQual[34:19]),
      .rxOpcode(rxQual[18:3]), .rxDaPause(rxQual[2]), .rxDaBcast(rxQual[1]),
      .rxDaMcast(rxQual[0]), .txFrameDone(txEvt), .txFrameErr(txQual[25]),
      .txFrameLen(txQual[24:9]), .txIsPause(txQual[8]), .txDaBcast(txQual[7]),
      .txDaMcast(txQual[6]), .tx_waited_medium(txQual[5]), .txCollCount(txQual[4:0]),
      .txCollisionEvt(txPulse[2]), .txLateCollEvt(txPulse[1]), .txAbandoned(txPulse[0])
   );
   pstat_mac_model pstat_mac_model_inst (
      .clk(clk), .rxEvt(rxEvt), .rxQual(rxQual), .txEvt(txEvt), .txQual(txQual),
      .txPulse(txPulse)
   );

   always #25 clk = ~clk;

   // ---------------------------------------------------------------
   // Result checking and bus tasks
   // ---------------------------------------------------------------
   // Every ack carries a word, writes and unmapped places included
   always @(posedge clk) begin
      if (wbAck === 1'b1) begin
         checked++;
         want = (expQ.size() > 0) ? expQ.pop_front() : 32'hxxxx_xxxx;
         if (wbDatOut !== want) begin
            miscompares++;
            $display("wrong value at %0t: got %h expected %h", $time, wbDatOut, want);
         end
      end
   end

   task automatic wrap_up();
      $display("checked %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : wrap_up

   // Caller stands just after a rising edge; one idle edge follows the release
   task automatic wbCycle(input logic [15:0] adr, input logic we, input logic [31:0] dat,
                          input logic [31:0] expVal);
      int n;
      n = 0;
      expQ.push_back(expVal);
      {wbCyc, wbStb, wbWe, wbAdr, wbSel, wbDatIn} <= {2'b11, we, adr, selMask, dat};
      do begin
         @(posedge clk);
         n++;
      end while (wbAck !== 1'b1 && n < 20);
      {wbCyc, wbStb} <= 2'b00;
      if (n >= 20) begin
         miscompares++;
         wrap_up();
      end
      @(posedge clk);
   endtask : wbCycle

   task automatic rdAll();
      for (int i = 0; i < 32; i++) begin
         wbCycle(OFS_BASE + 16'(4 * i), 1'b0, 32'h0, expCnt[i]);
         expCnt[i] = 32'h0;
      end
   endtask : rdAll

   task automatic rxFrame();
      logic [31:0] f;
      logic [15:0] len;
      logic        fcs, sym, part, ctl, err, sh, lg, bc, mc;
      int          k;
      f = $urandom;
      len = lenTab[f[19:16]];
      {fcs, sym, part, ctl} = {f[9] & f[10], f[11] & f[12], f[13] & f[14], f[4]};
      {bc, mc, err} = {f[7] & !f[6], f[8] | f[6], fcs | sym | part};
      {sh, lg} = {len < FRAME_MIN_LEN, len > FRAME_MAX_LEN};
      expCnt[0] += 32'(len);
      if (sh && !fcs) expCnt[1]++;
      if (sh && err) expCnt[2]++;
      if (lg && !fcs) expCnt[3]++;
      if (lg && err) expCnt[4]++;
      if (!sh && !lg && sym) expCnt[5]++;
      if (!sh && !lg && fcs) expCnt[part ? 7 : 6]++;
      if (ctl) expCnt[8]++;
      if (ctl && f[6] && f[5] && !sh && !fcs) expCnt[9]++;
      if (!sh && !lg && !err && !(mc && !bc && ctl)) expCnt[bc ? 10 : mc ? 11 : 12]++;
      k = 0;
      while (len > bucketHi[k]) k++;
      if (!sh) expCnt[13 + k]++;
      pstat_mac_model_inst.sendRx({len, fcs, sym, part, ctl ? ETHERTYPE_MAC_CTL : 16'h0800,
                                   f[5] ? OPCODE_PAUSE : 16'h0002, f[6], bc, mc});
   endtask : rxFrame

   // Collision pulses ride with the frame strobe; abandonment only on failed frames
   task automatic txFrame();
      logic [31:0] f;
      logic [15:0] len;
      logic [4:0]  coll;
      f = $urandom;
      len = lenTab[f[19:16]];
      coll = f[6] ? 5'(f[8:7]) : 5'h00;
      if (!f[0]) begin
         expCnt[21] += 32'(len);
         if (f[2]) expCnt[23]++;
         expCnt[f[3] ? 24 : f[4] ? 25 : 26]++;
         if (coll == 5'h01) expCnt[30]++;
         if (coll > 5'h01) expCnt[31]++;
      end
      if (f[5]) expCnt[27]++;
      if (f[11] && halfDup) expCnt[28]++;
      if (f[12]) expCnt[22]++;
      if (f[13] && f[0]) expCnt[29]++;
      pstat_mac_model_inst.sendTx({f[0], len, f[2], f[3], f[4], f[5], coll},
                                  {f[11], f[12], f[13] & f[0]});
   endtask : txFrame

   initial begin
      void'($urandom(81944));
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      rdAll();
      wbCycle(16'hed84, 1'b0, 32'h0, 32'h0);
      wbCycle(OFS_RX_OCTET_TOTAL, 1'b1, 32'hffff_ffff, 32'h0);
      for (int r = 0; r < 40; r++) begin
         if (r == 20) begin
            wbCycle(OFS_PORT_CTRL, 1'b1, 32'h1, 32'h0);
            halfDup = 1'b1;
            wbCycle(OFS_PORT_CTRL, 1'b0, 32'h0, 32'h1);
         end
         repeat (3) rxFrame();
         repeat (3) txFrame();
         rdAll();
      end
      rxFrame();
      // A read with no byte lanes returns the word but must not clear it
      selMask = 4'h0;
      wbCycle(OFS_RX_OCTET_TOTAL, 1'b0, 32'h0, expCnt[0]);
      selMask = 4'hf;
      oldVal = expCnt[0];
      expCnt[0] = 32'h0;
      fork
         wbCycle(OFS_RX_OCTET_TOTAL, 1'b0, 32'h0, oldVal);
         rxFrame();
      join
      rdAll();
      wrap_up();
   end
endmodule : test_pstat_counters
